/* File: core/clk_rst_params.svh */
// Offsets, field positions, reset values and timing counts of the clock and reset block
`ifndef CLK_RST_PARAMS_SVH
`define CLK_RST_PARAMS_SVH

`define OSC_CTRL_ADDR 4'h0
`define RESET_CAUSE_ADDR 4'h4
`define CUR_GROUP_LSB 12
`define NEW_GROUP_LSB 8
`define LOCK_BIT 5
`define CLOCK_FAIL_BIT 3
`define SWITCH_EN_BIT 0
`define KEY_LO_FIRST 8'h46
`define KEY_LO_SECOND 8'h57
`define KEY_HI_FIRST 8'h78
`define KEY_HI_SECOND 8'h9A
`define CAUSE_POR 0
`define CAUSE_BOR 1
`define CAUSE_EXT_RUN 2
`define CAUSE_EXT_SLEEP 3
`define CAUSE_WATCHDOG 4
`define CAUSE_SOFT 5
`define CAUSE_TRAP 6
`define CAUSE_ILLEGAL 7
`define RESET_CAUSE_POR_VAL 8'h03
`define CLK_PERIOD_NS 5
`define NS_PER_MS 1000000
`define BIAS_DELAY_NS 10000
`define POWERUP_TIMER_SHORT_MS 4
`define POWERUP_TIMER_MID_MS 16
`define POWERUP_TIMER_LONG_MS 64
`define OST_COUNT 1024
`define FAILSAFE_WINDOW_TICKS 4
`define PIN_FILTER_CYCLES 8

`endif

/* File: core/clk_rst_pkg.sv */
// Types shared by the clock switch, fail-safe monitor and reset sequencer
package clk_rst_pkg;
    typedef enum logic [1:0] {
        GRP_SECONDARY = 2'h0,
        GRP_FAST_RC = 2'h1,
        GRP_SLOW_RC = 2'h2,
        GRP_PRIMARY = 2'h3
    } group_t;

    typedef enum logic [3:0] {
        RS_BIAS = 4'h1,
        RS_POWERUP_TIMER = 4'h2,
        RS_WAIT = 4'h4,
        RS_RUN = 4'h8
    } rst_state_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'h1,
        SW_WAIT = 2'h2
    } sw_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic [1:0] be;
        logic we;
        logic re;
    } bus_req_t;

    typedef struct packed {
        logic [1:0] group_select_cfg;
        logic [3:0] primary_mode_cfg;
        logic [1:0] switch_monitor_cfg;
        logic [1:0] powerup_delay_cfg;
        logic watchdog_cfg_en;
    } cfg_t;

    typedef struct packed {
        logic primary_running;
        logic secondary_running;
        logic primary_tick;
        logic pll_lock;
        logic sysclk_edge;
        logic slow_rc_tick;
        logic first_clock_phase;
    } osc_status_t;

    typedef struct packed {
        logic brownout_reset;
        logic watchdog_timeout;
        logic reset_instr;
        logic trap_lockup;
        logic illegal_op;
    } reset_req_t;
endpackage : clk_rst_pkg

/* File: core/clock_switch_failsafe_reset.sv */
// Clock group switching, fail-safe clock monitor and power-on reset sequencing
//
// How it works
// - Slow RC on at power-up, later only if needed
// - Monitoring keeps slow RC on except Sleep
// - Clock failure traps and falls to fast RC
// - Failure loads fast RC, sets fail, clears enable
// - Watchdog clock unaffected by clock failure
// - Power-up expiry before oscillator runs traps
// - Not running, startup pending or unlocked traps
// - Four groups; primary mode from configuration
// - Current group read-only; new group requests
// - Power-on and brown-out load both group fields
// - Read-only lock and clock-fail status bits
// - Switch enable starts; clearing it aborts
// - Configuration 1x disables switching and monitor
// - Switching off: configuration selects, field reports
// - Low byte opens after 0x46 then 0x57
// - High byte opens after 0x78 then 0x9A
// - Reset causes kept apart in cause register
// - Pin reset filtered; pin never driven
// - Bias delay then selectable power-up delay
// - Release on first clock phase, reset vector
// - No clock without monitor keeps reset frozen
// - Start-up timer counts 1024 oscillator cycles
// - Code 01 selects the fast RC group
//
// Implementation choices: the placing of the registers and the plain strobed port.
`include "clk_rst_params.svh"
`timescale 1ns/1ps
`default_nettype none

module clock_switch_failsafe_reset #(
    parameter int unsigned POWERUP_TIMER_SHORT_CYC = `POWERUP_TIMER_SHORT_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
    parameter int unsigned POWERUP_TIMER_MID_CYC = `POWERUP_TIMER_MID_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
    parameter int unsigned POWERUP_TIMER_LONG_CYC = `POWERUP_TIMER_LONG_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire clk_rst_pkg::bus_req_t bus_i,
    output logic [15:0] rd_data_o,
    input wire clk_rst_pkg::cfg_t cfg_i,
    input wire clk_rst_pkg::osc_status_t osc_i,
    input wire clk_rst_pkg::reset_req_t rst_req_i,
    input wire logic external_reset_pin_n_i,
    input wire logic sleep_i,
    input wire logic soft_watchdog_enable_i,
    output logic external_reset_pin_o,
    output logic external_reset_pin_oe_o,
    output logic system_reset_o,
    output logic reset_vector_o,
    output logic clock_fail_trap_o,
    output logic slow_rc_enable_o,
    output logic [1:0] clock_group_o,
    output logic [3:0] primary_mode_o
);
    import clk_rst_pkg::*;

    localparam int unsigned BIAS_CYC = (`BIAS_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    group_t current_group;
    group_t new_group;
    logic switch_enable;
    logic clock_fail_flag;
    logic [7:0] reset_cause;
    rst_state_t rst_state;
    sw_state_t sw_state;
    logic [23:0] delay_cnt;
    logic [10:0] ost_cnt;
    logic [2:0] window_cnt;
    logic [3:0] pin_low_cnt;
    logic ext_reset_active;
    logic [1:0] key_seen;
    logic [1:0] unlock_open;
    logic [1:0] lane_accept;
    logic ctrl_hit;
    logic switch_allowed;
    logic monitor_en;
    logic ost_done;
    logic powerup_expire;
    logic fail_detect;
    logic startup_fail;
    logic fallback;
    logic other_reset;
    logic watchdog_on;
    logic [23:0] powerup_timer_cyc;

    // Configuration 1x turns off both switching and monitoring
    assign switch_allowed = !cfg_i.switch_monitor_cfg[1];
    assign monitor_en = (cfg_i.switch_monitor_cfg == 2'h0);
    assign ctrl_hit = (bus_i.addr == `OSC_CTRL_ADDR);
    assign ost_done = (ost_cnt == 11'(`OST_COUNT));
    assign watchdog_on = cfg_i.watchdog_cfg_en | soft_watchdog_enable_i;
    assign other_reset = ext_reset_active | (rst_req_i.watchdog_timeout & !sleep_i)
        | rst_req_i.reset_instr | rst_req_i.trap_lockup | rst_req_i.illegal_op;

    // Whether a group's oscillator is ready to be the system clock
    function automatic logic group_ready(input group_t g);
        logic pll_needed;
        pll_needed = cfg_i.primary_mode_cfg[2] & (cfg_i.primary_mode_cfg[1] | cfg_i.primary_mode_cfg[0]);
        case (g)
            GRP_PRIMARY: group_ready = osc_i.primary_running
                & (cfg_i.primary_mode_cfg[3] | ost_done) & (!pll_needed | osc_i.pll_lock);
            GRP_SECONDARY: group_ready = osc_i.secondary_running;
            default: group_ready = 1'b1;
        endcase
    endfunction : group_ready

    always_comb begin
        case (cfg_i.powerup_delay_cfg)
            2'h1: powerup_timer_cyc = 24'(POWERUP_TIMER_SHORT_CYC);
            2'h2: powerup_timer_cyc = 24'(POWERUP_TIMER_MID_CYC);
            2'h3: powerup_timer_cyc = 24'(POWERUP_TIMER_LONG_CYC);
            default: powerup_timer_cyc = 24'h000000;
        endcase
    end

    assign powerup_expire = (delay_cnt == 24'h000000)
        && ((rst_state == RS_POWERUP_TIMER) || (rst_state == RS_BIAS && powerup_timer_cyc == 24'h000000));
    assign startup_fail = powerup_expire && monitor_en && !group_ready(current_group);
    assign fail_detect = monitor_en && !sleep_i && (rst_state == RS_RUN) && osc_i.slow_rc_tick
        && !osc_i.sysclk_edge && (window_cnt == 3'(`FAILSAFE_WINDOW_TICKS - 1));
    assign fallback = fail_detect | startup_fail;

    // Reset pin noise filter; the pin is only ever an input here
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || external_reset_pin_n_i) begin
            pin_low_cnt <= 4'h0;
        end else if (pin_low_cnt != 4'(`PIN_FILTER_CYCLES)) begin
            pin_low_cnt <= pin_low_cnt + 4'h1;
        end
    end
    assign ext_reset_active = (pin_low_cnt == 4'(`PIN_FILTER_CYCLES));
    assign external_reset_pin_o = 1'b0;
    assign external_reset_pin_oe_o = 1'b0;

    // Power-on sequence: bias delay, power-up delay, first clock phase
    always_ff @(posedge clk_sys_i) begin
        reset_vector_o <= 1'b0;
        if (sys_rst_i || rst_req_i.brownout_reset) begin
            rst_state <= RS_BIAS;
            delay_cnt <= 24'(BIAS_CYC - 1);
            system_reset_o <= 1'b1;
        end else begin
            case (rst_state)
                RS_BIAS: begin
                    if (delay_cnt != 24'h000000) begin
                        delay_cnt <= delay_cnt - 24'h000001;
                    end else if (powerup_timer_cyc == 24'h000000) begin
                        rst_state <= RS_WAIT;
                    end else begin
                        rst_state <= RS_POWERUP_TIMER;
                        delay_cnt <= powerup_timer_cyc - 24'h000001;
                    end
                end
                RS_POWERUP_TIMER: begin
                    if (delay_cnt != 24'h000000) begin
                        delay_cnt <= delay_cnt - 24'h000001;
                    end else begin
                        rst_state <= RS_WAIT;
                    end
                end
                RS_WAIT: begin
                    // Without a clock no phase arrives and reset stays frozen
                    if (!other_reset && osc_i.first_clock_phase) begin
                        rst_state <= RS_RUN;
                        system_reset_o <= 1'b0;
                        reset_vector_o <= 1'b1;
                    end
                end
                RS_RUN: begin
                    if (other_reset) begin
                        rst_state <= RS_WAIT;
                        system_reset_o <= 1'b1;
                    end
                end
                default: begin
                    rst_state <= RS_BIAS;
                    delay_cnt <= 24'(BIAS_CYC - 1);
                    system_reset_o <= 1'b1;
                end
            endcase
        end
    end

    // Reset cause flags; hardware set wins over software clear
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reset_cause <= `RESET_CAUSE_POR_VAL;
        end else begin
            logic [7:0] set;
            logic [7:0] clr;
            set = 8'h00;
            set[`CAUSE_BOR] = rst_req_i.brownout_reset;
            set[`CAUSE_EXT_RUN] = ext_reset_active & !sleep_i;
            set[`CAUSE_EXT_SLEEP] = ext_reset_active & sleep_i;
            set[`CAUSE_WATCHDOG] = rst_req_i.watchdog_timeout & !sleep_i;
            set[`CAUSE_SOFT] = rst_req_i.reset_instr;
            set[`CAUSE_TRAP] = rst_req_i.trap_lockup;
            set[`CAUSE_ILLEGAL] = rst_req_i.illegal_op;
            clr = (bus_i.we && bus_i.be[0] && bus_i.addr == `RESET_CAUSE_ADDR) ? bus_i.wdata[7:0] : 8'h00;
            reset_cause <= (reset_cause & ~clr) | set;
        end
    end

    // Two-key unlock per byte lane, open for exactly one cycle
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane++) begin : g_unlock
            localparam logic [7:0] KEY_FIRST = (lane == 0) ? `KEY_LO_FIRST : `KEY_HI_FIRST;
            localparam logic [7:0] KEY_SECOND = (lane == 0) ? `KEY_LO_SECOND : `KEY_HI_SECOND;
            logic lane_write;
            assign lane_write = bus_i.we && ctrl_hit && bus_i.be[lane];
            assign lane_accept[lane] = lane_write && unlock_open[lane];
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i) begin
                    key_seen[lane] <= 1'b0;
                    unlock_open[lane] <= 1'b0;
                end else begin
                    key_seen[lane] <= lane_write && bus_i.wdata[lane*8 +: 8] == KEY_FIRST;
                    unlock_open[lane] <= lane_write && key_seen[lane]
                        && bus_i.wdata[lane*8 +: 8] == KEY_SECOND;
                end
            end
        end
    endgenerate

    // Oscillator start-up timer, restarted whenever the oscillator stops
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || rst_req_i.brownout_reset || sleep_i || !osc_i.primary_running) begin
            ost_cnt <= 11'h000;
        end else if (osc_i.primary_tick && !ost_done) begin
            ost_cnt <= ost_cnt + 11'h001;
        end
    end

    // Fail-safe window: slow RC ticks seen since the last system clock edge
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !monitor_en || sleep_i || osc_i.sysclk_edge || fallback) begin
            window_cnt <= 3'h0;
        end else if (osc_i.slow_rc_tick) begin
            window_cnt <= window_cnt + 3'h1;
        end
    end

    // Slow RC stays on before expiry, then only when needed
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            slow_rc_enable_o <= 1'b1;
        end else begin
            // Failure never touches the watchdog term
            slow_rc_enable_o <= (rst_state == RS_BIAS) || (rst_state == RS_POWERUP_TIMER)
                || (monitor_en && !sleep_i)
                || watchdog_on
                || (current_group == GRP_SLOW_RC);
        end
    end

    // Oscillator control: groups, switch sequence, fail-safe fallback
    always_ff @(posedge clk_sys_i) begin
        clock_fail_trap_o <= 1'b0;
        if (sys_rst_i || rst_req_i.brownout_reset) begin
            current_group <= group_t'(cfg_i.group_select_cfg);
            new_group <= group_t'(cfg_i.group_select_cfg);
            switch_enable <= 1'b0;
            clock_fail_flag <= 1'b0;
            sw_state <= SW_IDLE;
        end else if (fallback) begin
            current_group <= GRP_FAST_RC;
            clock_fail_flag <= 1'b1;
            switch_enable <= 1'b0;
            clock_fail_trap_o <= 1'b1;
            sw_state <= SW_IDLE;
        end else begin
            if (lane_accept[1] && switch_allowed) begin
                new_group <= group_t'(bus_i.wdata[`NEW_GROUP_LSB +: 2]);
            end
            if (lane_accept[0] && switch_allowed) begin
                switch_enable <= bus_i.wdata[`SWITCH_EN_BIT];
            end
            case (sw_state)
                SW_IDLE: begin
                    if (switch_enable && switch_allowed) begin
                        if (new_group == current_group) begin
                            switch_enable <= 1'b0;
                        end else begin
                            sw_state <= SW_WAIT;
                        end
                    end
                end
                SW_WAIT: begin
                    if (!switch_enable) begin
                        sw_state <= SW_IDLE;
                    end else if (group_ready(new_group)) begin
                        current_group <= new_group;
                        switch_enable <= 1'b0;
                        sw_state <= SW_IDLE;
                    end
                end
                default: sw_state <= SW_IDLE;
            endcase
        end
    end

    assign clock_group_o = current_group;
    assign primary_mode_o = cfg_i.primary_mode_cfg;

    // Register reads, answered one cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 16'h0000;
        end else if (bus_i.re) begin
            rd_data_o <= 16'h0000;
            if (ctrl_hit) begin
                rd_data_o[`CUR_GROUP_LSB +: 2] <= current_group;
                rd_data_o[`NEW_GROUP_LSB +: 2] <= new_group;
                rd_data_o[`LOCK_BIT] <= osc_i.pll_lock;
                rd_data_o[`CLOCK_FAIL_BIT] <= clock_fail_flag;
                rd_data_o[`SWITCH_EN_BIT] <= switch_enable;
            end else if (bus_i.addr == `RESET_CAUSE_ADDR) begin
                rd_data_o[7:0] <= reset_cause;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    trap_falls_back_a: assert property (clock_fail_trap_o |-> current_group == GRP_FAST_RC
        && clock_fail_flag && !switch_enable) else $error("trap without fast RC fallback");
    fail_status_a: assert property (fallback |=> clock_fail_trap_o && clock_fail_flag)
        else $error("fallback did not set clock fail");
    startup_trap_a: assert property (startup_fail |=> clock_fail_trap_o ##1 !clock_fail_trap_o)
        else $error("start-up failure not trapped once");
    slow_rc_powerup_timer_a: assert property (rst_state == RS_POWERUP_TIMER |=> slow_rc_enable_o)
        else $error("slow RC off before power-up expiry");
    slow_rc_mon_a: assert property (monitor_en && !sleep_i |=> slow_rc_enable_o)
        else $error("slow RC off while monitoring");
    group_load_a: assert property ($past(sys_rst_i) |-> current_group == $past(cfg_i.group_select_cfg)
        && new_group == $past(cfg_i.group_select_cfg)) else $error("groups not loaded from configuration");
    switch_locked_a: assert property (!switch_allowed |=> $stable(current_group))
        else $error("group moved with switching disabled");
    lo_unlock_a: assert property (lane_accept[0] |-> $past(bus_i.we) && $past(bus_i.wdata[7:0])
        == `KEY_LO_SECOND) else $error("low byte written without unlock");
    hi_locked_a: assert property (bus_i.we && ctrl_hit && bus_i.be[1] && !unlock_open[1]
        && !fallback |=> $stable(new_group)) else $error("high byte written while locked");
    abort_a: assert property (sw_state == SW_WAIT && !switch_enable && !fallback |=> sw_state == SW_IDLE
        && $stable(current_group)) else $error("cleared switch enable did not abort");
    release_a: assert property ($fell(system_reset_o) |-> reset_vector_o
        && $past(osc_i.first_clock_phase)) else $error("reset released off first clock phase");
    bias_hold_a: assert property (rst_state == RS_BIAS || rst_state == RS_POWERUP_TIMER |-> system_reset_o)
        else $error("reset released during power-on delays");
    pin_filter_a: assert property (external_reset_pin_n_i ##1 (!external_reset_pin_n_i) [*8]
        |-> !ext_reset_active ##1 ext_reset_active) else $error("pin reset filter length wrong");

    trap_seen_c: cover property (clock_fail_trap_o);
    switch_done_c: cover property (sw_state == SW_WAIT ##1 sw_state == SW_IDLE && !clock_fail_trap_o);
    abort_seen_c: cover property (sw_state == SW_WAIT && !switch_enable);
    release_seen_c: cover property (reset_vector_o);
endmodule : clock_switch_failsafe_reset

`default_nettype wire

/* File: bench/osc_model.sv */
// Oscillator sources: running flags, ticks, system clock edges and clock phase
`timescale 1ns/1ps
`default_nettype none
module osc_model (
    input wire logic clk_sys_i,
    input wire logic sysclk_stop_i,
    input wire logic pll_unlock_i,
    output var clk_rst_pkg::osc_status_t osc_o
);
    import clk_rst_pkg::*;
    logic [2:0] cnt = 3'h0;
    always_ff @(posedge clk_sys_i) begin
        cnt <= cnt + 3'h1;
    end
    always_comb begin
        osc_o.primary_running = 1'b1;
        osc_o.secondary_running = 1'b1;
        osc_o.primary_tick = 1'b1;
        osc_o.pll_lock = !pll_unlock_i;
        // Edges vanish while the source is failed
        osc_o.sysclk_edge = !sysclk_stop_i;
        osc_o.slow_rc_tick = (cnt == 3'h0);
        osc_o.first_clock_phase = (cnt[1:0] == 2'h0);
    end
endmodule : osc_model
`default_nettype wire

/* File: bench/tb_clock_switch_failsafe_reset.sv */
// Self-checking bench for clock switching, fail-safe monitor and reset sequencing
`timescale 1ns/1ps
`default_nettype none
module tb_clock_switch_failsafe_reset;
    import clk_rst_pkg::*;
    localparam int POWERUP_TIMER_S = 20;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    bus_req_t bus = '0;
    cfg_t cfg = '{2'h1, 4'hB, 2'h0, 2'h1, 1'b0};
    logic pin_n = 1'b1;
    logic stop = 1'b0;
    logic sleep = 1'b0;
    logic wd_soft = 1'b0;
    logic unlock = 1'b0;
    reset_req_t req = '0;
    osc_status_t osc;
    logic [15:0] rd_data;
    logic [15:0] rv;
    logic pin_o;
    logic pin_oe;
    logic sys_rst;
    logic vec;
    logic trap;
    logic slow_en;
    logic [1:0] grp;
    logic [3:0] pmode;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;

    clock_switch_failsafe_reset #(.POWERUP_TIMER_SHORT_CYC(POWERUP_TIMER_S), .POWERUP_TIMER_MID_CYC(40), .POWERUP_TIMER_LONG_CYC(80)) dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rd_data_o(rd_data), .cfg_i(cfg),
        .osc_i(osc), .rst_req_i(req), .external_reset_pin_n_i(pin_n), .sleep_i(sleep),
        .soft_watchdog_enable_i(wd_soft), .external_reset_pin_o(pin_o), .external_reset_pin_oe_o(pin_oe),
        .system_reset_o(sys_rst), .reset_vector_o(vec), .clock_fail_trap_o(trap),
        .slow_rc_enable_o(slow_en), .clock_group_o(grp), .primary_mode_o(pmode));
    osc_model partner (.clk_sys_i(clk_sys_i), .sysclk_stop_i(stop), .pll_unlock_i(unlock), .osc_o(osc));

    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic end_sim();
        if (n_fail == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail = n_fail + 1;
            end_sim();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
        @(posedge clk_sys_i);
        bus <= '{a, d, be, 1'b1, 1'b0};
    endtask : wr

    task automatic idle();
        @(posedge clk_sys_i);
        bus <= '0;
    endtask : idle

    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys_i);
        bus <= '{a, 16'h0000, 2'h0, 1'b0, 1'b1};
        idle();
        #1;
        rv = rd_data;
    endtask : rd

    task automatic key_wr(input logic hi, input logic [7:0] d);
        if (hi) begin
            wr(4'h0, 2'h2, 16'h7800);
            wr(4'h0, 2'h2, 16'h9A00);
            wr(4'h0, 2'h2, {d, 8'h00});
        end else begin
            wr(4'h0, 2'h1, 16'h0046);
            wr(4'h0, 2'h1, 16'h0057);
            wr(4'h0, 2'h1, {8'h00, d});
        end
        idle();
    endtask : key_wr

    task automatic wait_sys(input logic lvl, input int lim, output int n);
        n = 0;
        while (sys_rst !== lvl && n < lim) begin
            @(posedge clk_sys_i);
            #1;
            n = n + 1;
        end
    endtask : wait_sys

    task automatic do_reset(input cfg_t c, input int min_cyc);
        int n;
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        cfg <= c;
        repeat (20) @(posedge clk_sys_i);
        #1;
        check(16'(sys_rst), 16'h1);
        check(16'(slow_en), 16'h1);
        check(16'(grp), 16'(c.group_select_cfg));
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        wait_sys(1'b0, 3000, n);
        check(16'(n >= min_cyc), 16'h1);
        check(16'(vec), 16'h1);
        check({14'h0, pin_o, pin_oe}, 16'h0);
    endtask : do_reset

    task automatic s_power_on();
        do_reset('{2'h1, 4'hB, 2'h0, 2'h1, 1'b0}, 2000 + POWERUP_TIMER_S);
        rd(4'h4);
        check(rv, 16'h0003);
        rd(4'h0);
        check(16'({rv[13:12], rv[9:8], rv[5], rv[3], rv[0]}), 16'h002C);
        check(16'(slow_en), 16'h1);
        sleep <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check(16'(slow_en), 16'h0);
        sleep <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check(16'(slow_en), 16'h1);
    endtask : s_power_on

    task automatic s_switch();
        wr(4'h0, 2'h2, 16'h0300);
        idle();
        wr(4'h0, 2'h2, 16'h7800);
        idle();
        wr(4'h0, 2'h2, 16'h9A00);
        wr(4'h0, 2'h2, 16'h0300);
        idle();
        rd(4'h0);
        check(16'(rv[9:8]), 16'h1);
        key_wr(1'b1, 8'h03);
        key_wr(1'b0, 8'h01);
        repeat (100) begin
            if (grp !== 2'h3) @(posedge clk_sys_i);
        end
        #1;
        check(16'(grp), 16'h3);
        check(16'(pmode), 16'hB);
        rd(4'h0);
        check(16'({rv[13:12], rv[0]}), 16'h0006);
    endtask : s_switch

    task automatic s_failsafe();
        int n;
        n = 0;
        @(posedge clk_sys_i);
        stop <= 1'b1;
        while (trap !== 1'b1 && n < 200) begin
            @(posedge clk_sys_i);
            #1;
            n = n + 1;
        end
        check(16'(trap), 16'h1);
        check(16'(grp), 16'h1);
        rd(4'h0);
        check(16'({rv[13:12], rv[3], rv[0]}), 16'h0006);
        check(16'(slow_en), 16'h1);
        stop <= 1'b0;
    endtask : s_failsafe

    task automatic s_pin();
        int n;
        rd(4'h8);
        check(rv, 16'h0000);
        pin_n <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        pin_n <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        check(16'(sys_rst), 16'h0);
        pin_n <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
        check(16'(sys_rst), 16'h1);
        pin_n <= 1'b1;
        wait_sys(1'b0, 100, n);
        check(16'(vec), 16'h1);
        rd(4'h4);
        check(rv, 16'h0007);
        wr(4'h4, 2'h1, 16'h0007);
        idle();
        rd(4'h4);
        check(rv, 16'h0000);
        req.trap_lockup <= 1'b1;
        @(posedge clk_sys_i);
        req <= '0;
        #1;
        check(16'(sys_rst), 16'h1);
        wait_sys(1'b0, 100, n);
        rd(4'h4);
        check(rv, 16'h0040);
    endtask : s_pin

    task automatic s_startup();
        unlock <= 1'b1;
        do_reset('{2'h3, 4'h5, 2'h0, 2'h1, 1'b0}, 2000 + POWERUP_TIMER_S);
        check(16'(grp), 16'h1);
        rd(4'h0);
        check(16'({rv[13:12], rv[5], rv[3], rv[0]}), 16'h000A);
        key_wr(1'b0, 8'h01);
        rd(4'h0);
        check(16'({rv[13:12], rv[0]}), 16'h0003);
        key_wr(1'b0, 8'h00);
        rd(4'h0);
        check(16'({rv[13:12], rv[0]}), 16'h0002);
        check(16'(grp), 16'h1);
        unlock <= 1'b0;
    endtask : s_startup

    task automatic s_locked();
        do_reset('{2'h0, 4'hB, 2'h2, 2'h0, 1'b0}, 2000);
        check(16'(slow_en), 16'h0);
        wd_soft <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check(16'(slow_en), 16'h1);
        wd_soft <= 1'b0;
        key_wr(1'b1, 8'h01);
        key_wr(1'b0, 8'h01);
        repeat (20) @(posedge clk_sys_i);
        check(16'(grp), 16'h0);
        rd(4'h0);
        check(16'({rv[13:12], rv[9:8], rv[0]}), 16'h0000);
    endtask : s_locked

    initial begin
        s_power_on();
        s_switch();
        s_failsafe();
        s_pin();
        s_startup();
        s_locked();
        end_sim();
    end
endmodule : tb_clock_switch_failsafe_reset
`default_nettype wire
